/* src/macd_map.vh */
// offsets, field positions, command codes and reset values of the decoder
`ifndef MACD_MAP_VH
`define MACD_MAP_VH
// register index within one axis window (byte address = 4 * index)
`define MACD_IDX_CMD      3'h0
`define MACD_IDX_BUF      3'h1
`define MACD_IDX_MSTS     3'h2
`define MACD_IDX_MSTS_HI  3'h3
`define MACD_IDX_SSTS     3'h4
`define MACD_IDX_LAST     3'h4
// axis window stride is 32 bytes, selected by haddr[6:5]
`define MACD_AXIS_LSB     5
`define MACD_SPACE_MSB    7
// first environment register fields
`define MACD_ENV1_SDACT   4
`define MACD_ENV1_SDLTOFF 5
`define MACD_ENV1_SDPOL   6
`define MACD_ENV1_TRIG    18
`define MACD_ENV1_STOPM   19
// fifth and seventh environment register fields
`define MACD_ENV5_SYI_LSB 20
`define MACD_ENV5_SYO_LSB 16
`define MACD_ENV7_RT_LSB  0
// command codes
`define MACD_CMD_NOP      8'h00
`define MACD_CMD_AXSTA    8'h2A
`define MACD_CMD_STOP     8'h49
`define MACD_CMD_SDSTP    8'h4A
`define MACD_CMD_CSLOW    8'h50
`define MACD_CMD_STAFH    8'h51
`define MACD_CMD_RDWN     8'h52
`define MACD_CMD_RUPDN    8'h53
`define MACD_CMD_WPRFL    8'h81
`define MACD_CMD_WPRMD    8'h87
`define MACD_CMD_WPRIP    8'h88
`define MACD_CMD_WRENV1   8'h9C
`define MACD_CMD_WRENV5   8'hA0
`define MACD_CMD_WRENV7   8'hA2
`define MACD_CMD_WRCP5    8'hAB
`define MACD_CMD_WRIEN    8'hAC
`define MACD_CMD_RDPFL    8'hC1
`define MACD_CMD_RDPMD    8'hC7
`define MACD_CMD_RDPIP    8'hC8
`define MACD_CMD_RRENV5   8'hE0
`define MACD_CMD_RRENV7   8'hE2
`define MACD_CMD_RRCMP5   8'hEB
`define MACD_CMD_RRIRQ    8'hEC
`define MACD_CMD_RRSTS    8'hF1
`define MACD_CMD_RDERR    8'hF2
`define MACD_CMD_RDREM    8'hF4
`define MACD_CMD_RDSPD    8'hF5
// reset value of every data register
`define MACD_RST_WORD     32'h0000_0000
`endif

/* src/macd_top.v */
// four-axis command decoder and status logic behind an ahb-lite slave
`timescale 1ns/1ps
`include "macd_map.vh"

// Behaviour
// - preregister readback codes copy into buffer
// - status readback codes copy into buffer
// - write codes move buffer into register
// - env1 bit19 selects shared stop mode
// - env1 bit4 selects slowdown action
// - env1 bit6 sets slowdown input polarity
// - env1 bit5 disables slowdown latch
// - env1 bit18 selects level or edge start
// - two codes start constant-speed moves
// - two codes start ramped moves
// - single-axis start mimics shared start input
// - main bit1 shows pulse output active
// - main bit4 flags enabled event occurred
// - main bits 8-12 show comparator matches
// - main bits 14,15 show preregisters full
// - sub bits 8-10 show ramp phase
// - sub bits 11-15 show sensor inputs
// - extension bit4 shows motion direction
// - extension bits mirror input pins, start/stop inverted, slowdown after polarity
// - env5 selects sync source and timing
// - env7 low half holds suppression time
// - main status upper byte readable separately
module macd_top #(
   parameter AXES = 4
) (
   // clock and reset
   input  wire              sys_clk_i,
   input  wire              rstn_i,
   // ahb-lite slave
   input  wire              hsel_i,
   input  wire [31:0]       haddr_i,
   input  wire [1:0]        htrans_i,
   input  wire              hwrite_i,
   input  wire [2:0]        hsize_i,
   input  wire              hready_i,
   input  wire [31:0]       hwdata_i,
   output reg  [31:0]       hrdata_o,
   output wire              hreadyout_o,
   output wire              hresp_o,
   // shared start/stop pins, active low
   input  wire              shared_start_in_n_i,
   input  wire              shared_stop_in_n_i,
   // per-axis raw pins, active high except slowdown
   input  wire [AXES-1:0]   slowdown_in_i,
   input  wire [AXES-1:0]   alarm_in_i,
   input  wire [AXES-1:0]   plus_limit_i,
   input  wire [AXES-1:0]   minus_limit_i,
   input  wire [AXES-1:0]   origin_in_i,
   input  wire [AXES-1:0]   inpos_start_i,
   input  wire [AXES-1:0]   dr_plus_i,
   input  wire [AXES-1:0]   dr_minus_i,
   input  wire [AXES-1:0]   clear_in_i,
   input  wire [AXES-1:0]   latch_in_i,
   input  wire [AXES-1:0]   inposition_in_i,
   // per-axis state from the pulse generator
   input  wire [AXES-1:0]   moving_i,
   input  wire [AXES-1:0]   accel_i,
   input  wire [AXES-1:0]   decel_i,
   input  wire [AXES-1:0]   cruise_i,
   input  wire [AXES-1:0]   dir_minus_i,
   input  wire [AXES*5-1:0] cmp_met_i,
   input  wire [AXES*32-1:0] event_i,
   input  wire [AXES*32-1:0] err_status_i,
   input  wire [AXES*32-1:0] rem_pulse_i,
   input  wire [AXES*32-1:0] speed_i,
   // per-axis motion requests
   output wire [AXES-1:0]   start_o,
   output wire [AXES*2-1:0] start_kind_o,
   output wire [AXES-1:0]   stop_now_o,
   output wire [AXES-1:0]   stop_decel_o,
   output wire [AXES-1:0]   slow_to_low_o,
   // per-axis configuration outputs
   output wire [AXES*32-1:0] cmp_five_o,
   output wire [AXES*2-1:0] sync_source_axis_o,
   output wire [AXES*4-1:0] sync_out_timing_o,
   output wire [AXES*16-1:0] vib_suppress_time_o
);

   // bus state
   reg              wr_pend_r;
   reg              rd_wait_r;
   reg              acc_ok_r;
   reg  [1:0]       acc_axis_r;
   reg  [2:0]       acc_idx_r;
   reg              start_prev_r;
   wire             acc_take;
   wire             addr_ok;
   wire             wr_do;
   wire             sta_lvl;
   wire             sta_edge;
   wire             stp_act;
   wire [31:0]      axis_rd [0:AXES-1];

   // a transfer is taken only when the bus is ready and htrans is active
   assign acc_take = hsel_i & htrans_i[1] & hready_i;
   assign addr_ok  = (haddr_i[31:`MACD_SPACE_MSB] == 25'h000_0000) &
                     (haddr_i[1:0] == 2'h0) &
                     (haddr_i[4:2] <= `MACD_IDX_LAST);
   // reads insert one wait state so the data comes from a flop
   assign hreadyout_o = ~rd_wait_r;
   assign hresp_o     = 1'b0;
   assign wr_do       = wr_pend_r & acc_ok_r;

   // shared inputs: edge detector sits on the synchronous pin directly
   assign sta_lvl  = ~shared_start_in_n_i;
   assign sta_edge = sta_lvl & ~start_prev_r;
   assign stp_act  = ~shared_stop_in_n_i;

   // address phase capture and registered read data
   always @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         wr_pend_r    <= 1'b0;
         rd_wait_r    <= 1'b0;
         acc_ok_r     <= 1'b0;
         acc_axis_r   <= 2'h0;
         acc_idx_r    <= 3'h0;
         start_prev_r <= 1'b0;
         hrdata_o     <= `MACD_RST_WORD;
      end else begin
         start_prev_r <= sta_lvl;
         wr_pend_r    <= acc_take & hwrite_i;
         rd_wait_r    <= acc_take & ~hwrite_i;
         if (acc_take) begin
            acc_ok_r   <= addr_ok;
            acc_axis_r <= haddr_i[6:5];
            acc_idx_r  <= haddr_i[4:2];
         end
         if (rd_wait_r) begin
            // unmapped reads answer zero
            hrdata_o <= acc_ok_r ? axis_rd[acc_axis_r] : `MACD_RST_WORD;
         end
      end
   end

   genvar a;
   generate
      for (a = 0; a < AXES; a = a + 1) begin : g_axis
         reg  [31:0] buf_r;
         reg  [31:0] pre_fl_r;
         reg  [31:0] pre_ip_r;
         reg  [31:0] pre_md_r;
         reg  [31:0] env1_r;
         reg  [31:0] env5_r;
         reg  [31:0] env7_r;
         reg  [31:0] irq_en_r;
         reg  [31:0] cmp5_r;
         reg         evt_flag_r;
         reg         pre_full_r;
         reg         cmp5_full_r;
         reg         slw_latch_r;
         reg         start_r;
         reg  [1:0]  kind_r;
         reg         stop_now_r;
         reg         stop_dec_r;
         reg  [31:0] rd_word;
         wire        sel;
         wire        cmd_we;
         wire        buf_we;
         wire        ms_read;
         wire [7:0]  cmd;
         wire        slw_act;
         wire        slw_eff;
         wire        ext_start;
         wire        evt_hit;
         wire [15:0] main_status_word;
         wire [15:0] sub_status_word;
         wire [31:0] extension_status;

         assign sel     = ({30'h0000_0000, acc_axis_r} == a);
         assign cmd_we  = wr_do & sel & (acc_idx_r == `MACD_IDX_CMD);
         assign buf_we  = wr_do & sel & (acc_idx_r == `MACD_IDX_BUF);
         assign ms_read = rd_wait_r & acc_ok_r & sel &
                          ((acc_idx_r == `MACD_IDX_MSTS) |
                           (acc_idx_r == `MACD_IDX_MSTS_HI));
         assign cmd     = hwdata_i[7:0];

         // slowdown input conditioning
         assign slw_act = env1_r[`MACD_ENV1_SDPOL] ? slowdown_in_i[a]
                                                  : ~slowdown_in_i[a];
         assign slw_eff = env1_r[`MACD_ENV1_SDLTOFF] ? slw_act
                                                    : slw_latch_r;
         // level mode waits for the axis to be idle, else it would re-fire
         assign ext_start = env1_r[`MACD_ENV1_TRIG] ? sta_edge :
                            (sta_lvl & ~moving_i[a] & ~start_r);
         assign evt_hit = |(event_i[a*32 +: 32] & irq_en_r);

         // status words
         assign main_status_word = {cmp5_full_r, pre_full_r, 1'b0,
                                    cmp_met_i[a*5 +: 5],
                                    3'h0, evt_flag_r, 2'h0,
                                    moving_i[a], 1'b0};
         assign sub_status_word  = {slw_eff, origin_in_i[a], minus_limit_i[a],
                                    plus_limit_i[a], alarm_in_i[a],
                                    cruise_i[a], decel_i[a], accel_i[a],
                                    8'h00};
         assign extension_status = {15'h0000, inposition_in_i[a], slw_act,
                                    latch_in_i[a], clear_in_i[a],
                                    dr_minus_i[a], dr_plus_i[a], 2'h0,
                                    inpos_start_i[a], 1'b0, stp_act, sta_lvl,
                                    dir_minus_i[a], 4'h0};

         // register-window read mux
         always @* begin
            case (acc_idx_r)
               `MACD_IDX_BUF:     rd_word = buf_r;
               `MACD_IDX_MSTS:    rd_word = {16'h0000, main_status_word};
               `MACD_IDX_MSTS_HI: rd_word = {24'h00_0000,
                                             main_status_word[15:8]};
               `MACD_IDX_SSTS:    rd_word = {16'h0000, sub_status_word};
               default:           rd_word = `MACD_RST_WORD;
            endcase
         end
         assign axis_rd[a] = rd_word;

         // command execution, buffer, and status flags
         always @(posedge sys_clk_i) begin
            if (!rstn_i) begin
               buf_r       <= `MACD_RST_WORD;
               pre_fl_r    <= `MACD_RST_WORD;
               pre_ip_r    <= `MACD_RST_WORD;
               pre_md_r    <= `MACD_RST_WORD;
               env1_r      <= `MACD_RST_WORD;
               env5_r      <= `MACD_RST_WORD;
               env7_r      <= `MACD_RST_WORD;
               irq_en_r    <= `MACD_RST_WORD;
               cmp5_r      <= `MACD_RST_WORD;
               evt_flag_r  <= 1'b0;
               pre_full_r  <= 1'b0;
               cmp5_full_r <= 1'b0;
               slw_latch_r <= 1'b0;
               start_r     <= 1'b0;
               kind_r      <= 2'h0;
               stop_now_r  <= 1'b0;
               stop_dec_r  <= 1'b0;
            end else begin
               start_r    <= 1'b0;
               stop_now_r <= stp_act & ~env1_r[`MACD_ENV1_STOPM];
               stop_dec_r <= (stp_act & env1_r[`MACD_ENV1_STOPM]) |
                             (slw_eff & env1_r[`MACD_ENV1_SDACT]);
               if (buf_we) begin
                  buf_r <= hwdata_i;
               end
               if (ext_start) begin
                  start_r <= 1'b1;
                  kind_r  <= pre_md_r[1:0];
               end
               if (cmd_we) begin
                  case (cmd)
                     `MACD_CMD_CSLOW, `MACD_CMD_STAFH,
                     `MACD_CMD_RDWN, `MACD_CMD_RUPDN: begin
                        start_r     <= 1'b1;
                        kind_r      <= cmd[1:0];
                        pre_full_r  <= 1'b0;
                        slw_latch_r <= 1'b0;
                     end
                     `MACD_CMD_AXSTA: begin
                        start_r <= 1'b1;
                        kind_r  <= pre_md_r[1:0];
                     end
                     `MACD_CMD_STOP:   stop_now_r <= 1'b1;
                     `MACD_CMD_SDSTP:  stop_dec_r <= 1'b1;
                     `MACD_CMD_WPRFL: begin
                        pre_fl_r   <= buf_r;
                        pre_full_r <= 1'b1;
                     end
                     `MACD_CMD_WPRMD: begin
                        pre_md_r   <= buf_r;
                        pre_full_r <= 1'b1;
                     end
                     `MACD_CMD_WPRIP: begin
                        pre_ip_r   <= buf_r;
                        pre_full_r <= 1'b1;
                     end
                     `MACD_CMD_WRENV1: env1_r   <= buf_r;
                     `MACD_CMD_WRENV5: env5_r   <= buf_r;
                     `MACD_CMD_WRENV7: env7_r   <= buf_r;
                     `MACD_CMD_WRIEN:  irq_en_r <= buf_r;
                     `MACD_CMD_WRCP5:  begin
                        cmp5_r      <= buf_r;
                        cmp5_full_r <= moving_i[a];
                     end
                     `MACD_CMD_RDPFL:  buf_r <= pre_fl_r;
                     `MACD_CMD_RDPMD:  buf_r <= pre_md_r;
                     `MACD_CMD_RDPIP:  buf_r <= pre_ip_r;
                     `MACD_CMD_RRENV5: buf_r <= env5_r;
                     `MACD_CMD_RRENV7: buf_r <= env7_r;
                     `MACD_CMD_RRCMP5: buf_r <= cmp5_r;
                     `MACD_CMD_RRIRQ:  buf_r <= irq_en_r;
                     `MACD_CMD_RRSTS:  buf_r <= extension_status;
                     `MACD_CMD_RDERR:
                        buf_r <= err_status_i[a*32 +: 32];
                     `MACD_CMD_RDREM:
                        buf_r <= rem_pulse_i[a*32 +: 32];
                     `MACD_CMD_RDSPD:  buf_r <= speed_i[a*32 +: 32];
                     default: ;
                  endcase
               end
               // cmp5 preregister drains once the axis is idle
               if (!moving_i[a] && !cmd_we) begin
                  cmp5_full_r <= 1'b0;
               end
               // set wins over clear for the sticky flags
               if (ms_read) begin
                  evt_flag_r <= 1'b0;
               end
               if (evt_hit) begin
                  evt_flag_r <= 1'b1;
               end
               if (slw_act) begin
                  slw_latch_r <= 1'b1;
               end
            end
         end

         // outputs of this axis
         assign start_o[a]                   = start_r;
         assign start_kind_o[a*2 +: 2]       = kind_r;
         assign stop_now_o[a]                = stop_now_r;
         assign stop_decel_o[a]              = stop_dec_r;
         assign slow_to_low_o[a]             = slw_eff &
                                               ~env1_r[`MACD_ENV1_SDACT];
         assign cmp_five_o[a*32 +: 32]       = cmp5_r;
         assign sync_source_axis_o[a*2 +: 2] =
            env5_r[`MACD_ENV5_SYI_LSB +: 2];
         assign sync_out_timing_o[a*4 +: 4]  =
            env5_r[`MACD_ENV5_SYO_LSB +: 4];
         assign vib_suppress_time_o[a*16 +: 16] =
            env7_r[`MACD_ENV7_RT_LSB +: 16];
      end
   endgenerate

endmodule // macd_top

/* bench/macd_properties.sv */
// assertions on the decoder's bus, motion-request and configuration ports
`timescale 1ns/1ps
`include "macd_map.vh"
module macd_properties #(
   parameter AXES = 4
) (
   // clock, reset and bus
   input wire               sys_clk_i,
   input wire               rstn_i,
   input wire               hsel_i,
   input wire [31:0]        haddr_i,
   input wire [1:0]         htrans_i,
   input wire               hwrite_i,
   input wire               hready_i,
   input wire [31:0]        hwdata_i,
   input wire               hreadyout_o,
   input wire               hresp_o,
   // motion requests and configuration
   input wire [AXES-1:0]    start_o,
   input wire [AXES*2-1:0]  start_kind_o,
   input wire [AXES-1:0]    stop_now_o,
   input wire [AXES-1:0]    stop_decel_o,
   input wire [AXES*2-1:0]  sync_source_axis_o,
   input wire [AXES*16-1:0] vib_suppress_time_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   logic        wph_r;
   logic [31:0] adr_r;
   logic [1:0]  ax_r;
   logic [1:0]  kd_r;
   wire acc = hsel_i & htrans_i[1] & hready_i;
   wire cmt = wph_r & hready_i & (adr_r[31:7] == 0) & (adr_r[4:0] == 0);
   // keep the address phase so the commit edge is known
   always @(posedge sys_clk_i) begin
      if (!rstn_i)
         wph_r <= 1'b0;
      else if (hready_i)
         wph_r <= acc & hwrite_i;
      if (hready_i)
         adr_r <= haddr_i;
      if (cmt) begin
         ax_r <= adr_r[6:5];
         kd_r <= hwdata_i[1:0];
      end
   end
   sequence s_code(c);
      cmt && hwdata_i[7:0] == c;
   endsequence
   sequence s_go;
      ##[1:2] (start_o[ax_r] && start_kind_o[2*ax_r +: 2] == kd_r);
   endsequence
   a_okay_resp: assert property (hresp_o == 1'b0)
      else $error("bus response not okay");
   a_read_wait: assert property (
      acc && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait state wrong");
   a_write_zero: assert property (acc && hwrite_i |=> hreadyout_o)
      else $error("write was stalled");
   a_start_cmd: assert property (
      cmt && hwdata_i[7:2] == 6'h14 |-> s_go)
      else $error("start code gave no start of that kind");
   a_single_go: assert property (
      s_code(`MACD_CMD_AXSTA) |-> ##[1:2] start_o[ax_r])
      else $error("single axis start missing");
   a_stop_now: assert property (
      s_code(`MACD_CMD_STOP) |-> ##[1:2] stop_now_o[ax_r])
      else $error("immediate stop missing");
   a_stop_decel: assert property (
      s_code(`MACD_CMD_SDSTP) |-> ##[1:2] stop_decel_o[ax_r])
      else $error("decelerating stop missing");
   a_start_pulse: assert property (start_o[0] |=> !start_o[0])
      else $error("start request longer than a cycle");
   a_sync_hold: assert property (
      !$stable(sync_source_axis_o) |-> $past(cmt) || $past(cmt, 2))
      else $error("sync selection moved without a command");
   a_vib_hold: assert property (
      !$stable(vib_suppress_time_o) |-> $past(cmt) || $past(cmt, 2))
      else $error("suppression time moved without a command");
endmodule // macd_properties

/* bench/macd_host.sv */
// bus master standing in for the host processor
`timescale 1ns/1ps
module macd_host (
   // clock and answer
   input  wire         clk_i,
   input  wire         hready_i,
   input  wire  [31:0] hrdata_i,
   // request
   output logic        hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0]  htrans_o,
   output logic        hwrite_o,
   output logic [2:0]  hsize_o,
   output logic [31:0] hwdata_o
);
   // idle bus at time zero
   initial begin
      hsel_o = 1'b0;
      haddr_o = 32'h0000_0000;
      htrans_o = 2'b00;
      hwrite_o = 1'b0;
      hsize_o = 3'b010;
      hwdata_o = 32'h0000_0000;
   end
   // one word transfer, each phase held until hready is seen high
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      hsel_o <= 1'b1;
      htrans_o <= 2'b10;
      haddr_o <= a;
      hwrite_o <= w;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      htrans_o <= 2'b00;
      hwdata_o <= d;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      q = hrdata_i;
      // stale write data must not be trusted once released
      hwdata_o <= ~d;
   endtask
endmodule // macd_host

/* bench/macd_top_bench.sv */
// self-checking bench for the four-axis command decoder
`timescale 1ns/1ps
`include "macd_map.vh"
module macd_top_bench;
   logic         clk, rstn, rdp, sta_n, stp_n;
   wire          hsel, hwrite, hready, hresp;
   wire  [31:0]  haddr, hwdata, hrdata;
   wire  [1:0]   htrans;
   wire  [2:0]   hsize;
   logic [3:0]   slw, mv, alm, pel, mel, org, pcs, drp, drm, clr, ltc, inp;
   logic [3:0]   acc, dec, cru, dir, pf, ab, slf;
   logic [19:0]  cmp;
   logic [127:0] ev, err, rem, spd;
   wire  [3:0]   start, now, dcl, slow;
   wire  [7:0]   kind, ssa;
   wire  [15:0]  sot;
   wire  [63:0]  vib;
   wire  [127:0] c5;
   logic [31:0]  exp_q[$];
   logic [5:0]   st_q[$];
   logic [31:0]  q, v, irq[4];
   logic [1:0]   a, pmd[4];
   int           failures, n_checks;
   logic [7:0]   wc[7] = '{8'h81, 8'h87, 8'h88, 8'hAB, 8'hAC, 8'hA0, 8'hA2};
   logic [7:0]   rc[7] = '{8'hC1, 8'hC7, 8'hC8, 8'hEB, 8'hEC, 8'hE0, 8'hE2};
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   macd_host u_host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hsize_o(hsize), .hwdata_o(hwdata));
   macd_top dut (.sys_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(hsize), .hready_i(hready), .hwdata_i(hwdata),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .shared_start_in_n_i(sta_n), .shared_stop_in_n_i(stp_n),
      .slowdown_in_i(slw), .alarm_in_i(alm), .plus_limit_i(pel),
      .minus_limit_i(mel), .origin_in_i(org), .inpos_start_i(pcs),
      .dr_plus_i(drp), .dr_minus_i(drm), .clear_in_i(clr),
      .latch_in_i(ltc), .inposition_in_i(inp), .moving_i(mv),
      .accel_i(acc), .decel_i(dec), .cruise_i(cru), .dir_minus_i(dir),
      .cmp_met_i(cmp), .event_i(ev), .err_status_i(err),
      .rem_pulse_i(rem), .speed_i(spd), .start_o(start),
      .start_kind_o(kind), .stop_now_o(now), .stop_decel_o(dcl),
      .slow_to_low_o(slow), .cmp_five_o(c5), .sync_source_axis_o(ssa),
      .sync_out_timing_o(sot), .vib_suppress_time_o(vib));
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic chks(input logic [5:0] e, input logic [5:0] g);
      chk({26'h0, e}, {26'h0, g});
   endtask
   task automatic wr(input logic [1:0] x, input logic [2:0] r,
                     input logic [31:0] d);
      u_host.xfer(1'b1, {25'h0, x, r, 2'b00}, d, q);
   endtask
   task automatic rd(input logic [1:0] x, input logic [2:0] r,
                     input logic [31:0] e);
      exp_q.push_back(e);
      u_host.xfer(1'b0, {25'h0, x, r, 2'b00}, 32'h0000_0000, q);
   endtask
   task automatic cmd(input logic [1:0] x, input logic [7:0] c);
      wr(x, `MACD_IDX_CMD, {24'h00_0000, c});
   endtask
   function automatic logic [31:0] mst(input logic [1:0] x);
      mst = {16'h0000, ab[x] & mv[x], pf[x], 1'b0, cmp[5*x +: 5], 3'b000,
             |(ev[32*x +: 32] & irq[x]), 2'b00, mv[x], 1'b0};
   endfunction
   // status words of one axis, expected from the pins and the model
   task automatic status(input logic [1:0] x);
      rd(x, `MACD_IDX_MSTS, mst(x));
      rd(x, `MACD_IDX_MSTS_HI, mst(x) >> 8);
      rd(x, `MACD_IDX_SSTS, {16'h0000, slf[x], org[x], mel[x], pel[x],
         alm[x], cru[x], dec[x], acc[x], 8'h00});
      cmd(x, `MACD_CMD_RRSTS);
      rd(x, `MACD_IDX_BUF, {15'h0000, inp[x], ~slw[x], ltc[x], clr[x], drm[x],
         drp[x], 2'b00, pcs[x], 1'b0, ~stp_n, ~sta_n, dir[x],
         4'h0});
   endtask
   // read data against the oldest note
   always @(posedge clk) begin
      if (rdp && hready)
         chk(exp_q.size() ? exp_q.pop_front() : 32'hx, hrdata);
      if (hready)
         rdp <= hsel && htrans[1] && !hwrite;
   end
   // start requests against the oldest note, axis one-hot and kind
   always @(posedge clk) begin
      if (|start)
         chks(st_q.size() ? st_q.pop_front() : 6'hx, {start,
            kind[2*(start[1] ? 1 : start[2] ? 2 : start[3] ? 3 : 0) +: 2]
            });
   end
   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // a hang is cut short long after the sequence should have ended
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      results();
   end
   initial begin
      {rdp, rstn, sta_n, stp_n, slw, mv, pf, ab, slf} = {4'b0011, 20'hF_0000};
      {alm, pel, mel, org, pcs, drp, drm, clr, ltc, inp} = 40'h0;
      {acc, dec, cru, dir, cmp, ev, err, rem, spd} = 0;
      irq = '{4{32'h0000_0000}};
      pmd = '{4{2'b00}};
      failures = 0;
      n_checks = 0;
      v = $urandom(1886);
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      {alm, pel, mel, org, pcs, drp, drm} <= 28'($urandom);
      {clr, ltc, inp, acc, dec, cru, dir} <= 28'($urandom);
      cmp <= 20'($urandom);
      ev <= {$urandom, $urandom, $urandom, $urandom};
      err <= {$urandom, $urandom, $urandom, $urandom};
      rem <= {$urandom, $urandom, $urandom, $urandom};
      spd <= {$urandom, $urandom, $urandom, $urandom};
      @(posedge clk);
      // each write code except env1, a refused code between, then its readback code
      for (int i = 0; i < 7; i++) begin
         a = 2'($urandom);
         v = $urandom;
         wr(a, `MACD_IDX_BUF, v);
         cmd(a, wc[i]);
         wr(a, `MACD_IDX_BUF, ~v);
         cmd(a, 8'h3F);
         rd(a, `MACD_IDX_BUF, ~v);
         cmd(a, rc[i]);
         rd(a, `MACD_IDX_BUF, v);
         pf[a] = pf[a] | (i < 3);
         pmd[a] = (i == 1) ? v[1:0] : pmd[a];
         irq[a] = (i == 4) ? v : irq[a];
         if (i == 3)
            chk(c5[32*a +: 32], v);
         if (i == 5)
            chk({ssa[2*a +: 2], sot[4*a +: 4]}, v[21:16]);
         if (i == 6)
            chk(vib[16*a +: 16], v[15:0]);
      end
      mv <= 4'b0101;
      cmd(0, `MACD_CMD_WRCP5);
      ab[0] = 1'b1;
      for (int i = 0; i < 4; i++)
         status(i[1:0]);
      cmd(1, `MACD_CMD_RDERR);
      rd(1, `MACD_IDX_BUF, err[63:32]);
      cmd(2, `MACD_CMD_RDREM);
      rd(2, `MACD_IDX_BUF, rem[95:64]);
      cmd(3, `MACD_CMD_RDSPD);
      rd(3, `MACD_IDX_BUF, spd[127:96]);
      // every start code; the queue flag must drop after each but the single-axis start
      for (int k = 0; k < 4; k++) begin
         a = 2'($urandom);
         st_q.push_back({4'b0001 << a, k[1:0]});
         cmd(a, {6'h14, k[1:0]});
         pf[a] = 1'b0;
         status(a);
      end
      st_q.push_back({4'b0001 << a, pmd[a]});
      cmd(a, `MACD_CMD_AXSTA);
      // edge-triggered shared start on the one idle axis
      wr(0, `MACD_IDX_BUF, 32'h0004_0000);
      cmd(0, `MACD_CMD_WRENV1);
      mv <= 4'b1110;
      ab = 4'b0000;
      st_q.push_back({4'b0001, pmd[0]});
      sta_n <= 1'b0;
      repeat (6) @(posedge clk);
      sta_n <= 1'b1;
      // latched slowdown, active low, then polarity, latch off, action
      slw[1] <= 1'b0;
      repeat (2) @(posedge clk);
      slw[1] <= 1'b1;
      repeat (4) @(posedge clk);
      chk(slow[1], 1'b1);
      slf[1] = 1'b1;
      status(1);
      st_q.push_back({4'b0010, 2'b00});
      cmd(1, `MACD_CMD_CSLOW);
      slf[1] = 1'b0;
      for (int k = 0; k < 3; k++) begin
         wr(1, `MACD_IDX_BUF, (k == 2) ? 32'h0000_0070 : 32'h0000_0060);
         cmd(1, `MACD_CMD_WRENV1);
         slw[1] <= (k != 1);
         repeat (4) @(posedge clk);
         chk(slow[1], k == 0);
      end
      slw[1] <= 1'b1;
      // shared stop: immediate on axis 2, decelerating on axis 3
      wr(3, `MACD_IDX_BUF, 32'h0008_0000);
      cmd(3, `MACD_CMD_WRENV1);
      stp_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk({now[3:2], dcl[3:2]}, 4'b0110);
      stp_n <= 1'b1;
      cmd(2, `MACD_CMD_STOP);
      cmd(2, `MACD_CMD_SDSTP);
      repeat (5) @(posedge clk);
      chk(st_q.size(), 0);
      results();
   end
endmodule // macd_top_bench

bind macd_top macd_properties #(.AXES(AXES)) u_props (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .hwdata_i(hwdata_i), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .start_o(start_o), .start_kind_o(start_kind_o),
   .stop_now_o(stop_now_o), .stop_decel_o(stop_decel_o),
   .sync_source_axis_o(sync_source_axis_o),
   .vib_suppress_time_o(vib_suppress_time_o));
